// *** rss_params.svh ***
// constants of the reset source sequencer
`ifndef RSS_PARAMS_SVH
`define RSS_PARAMS_SVH
`define RSS_CLK_MHZ 100
`define RSS_POWERUP_DELAY_TIMER_MS 64
`define RSS_POWERUP_DELAY_TIMER_CYCLES (`RSS_POWERUP_DELAY_TIMER_MS * 1000 * `RSS_CLK_MHZ)
`define RSS_POWERUP_DELAY_TIMER_W 23
`define RSS_BOR_FILT_NS 1000
`define RSS_PIN_FILT_NS 200
`define RSS_BOR_FILT_CYCLES ((`RSS_BOR_FILT_NS * `RSS_CLK_MHZ + 999) / 1000)
`define RSS_PIN_FILT_CYCLES ((`RSS_PIN_FILT_NS * `RSS_CLK_MHZ + 999) / 1000)
`define RSS_FILT_W 8
`define RSS_ADR_W 4
`define RSS_ADR_BROWNOUT_CONTROL 4'h0
`define RSS_ADR_PIN_CONTROL 4'h4
`define RSS_ADR_RESET_STATUS 4'h8
`define RSS_BIT_SOFT_ENABLE 7
`define RSS_BIT_READY 0
`define RSS_BIT_PULLUP 0
`define RSS_BIT_PIN_LEVEL 1
`define RSS_BIT_CORE_RESET 0
`define RSS_BIT_BOR_HOLD 1
`define RSS_BIT_PIN_HOLD 2
`define RSS_BIT_PHASE_LO 4
`define RSS_BIT_PHASE_HI 5
`define RSS_SYNC_POR 0
`define RSS_SYNC_BELOW 1
`define RSS_SYNC_READY 2
`define RSS_SYNC_PIN 3
`define RSS_MODE_ALWAYS_ACTIVE 2'b11
`define RSS_MODE_OFF_IN_SLEEP 2'b10
`define RSS_MODE_SOFTWARE 2'b01
`define RSS_MODE_ALWAYS_INACTIVE 2'b00
`define RSS_RST_SOFT_ENABLE 1'b1
`define RSS_RST_PULLUP 1'b0
`define RSS_RST_SYNC 4'h8
`endif

// *** rss_pkg.sv ***
// types of the reset source sequencer
`include "rss_params.svh"
package rss_pkg;
  typedef enum logic [1:0] {
    RSS_PH_POWER = 2'b00,
    RSS_PH_TIMER = 2'b01,
    RSS_PH_OSC = 2'b10,
    RSS_PH_RUN = 2'b11
  } rss_phase_type;

  typedef struct packed {
    logic powerup_delay_enable_n;
    logic [1:0] brownout_mode_select;
    logic brownout_level_select;
    logic external_reset_pin_enable;
    logic low_voltage_program_enable;
  } rss_config_type;

  typedef struct packed {
    logic watchdog_timeout;
    logic reset_instruction;
    logic stack_overflow;
    logic stack_underflow;
    logic program_mode_exit;
  } rss_source_type;

  typedef struct packed {
    logic [3:0] sync1;
    logic [3:0] sync2;
    rss_phase_type phase;
    logic [`RSS_POWERUP_DELAY_TIMER_W-1:0] powerup_delay_timer_count;
    logic [`RSS_FILT_W-1:0] bor_count;
    logic bor_hold;
    logic [`RSS_FILT_W-1:0] pin_count;
    logic pin_filt;
    logic soft_enable;
    logic pullup_soft;
    logic core_reset;
    logic ack;
    logic [31:0] rdata;
  } rss_state_type;
endpackage : rss_pkg

// *** rss_top.sv ***
// reset source sequencer with a classic wishbone register slave
// Functional notes
// - many reset sources merge into one reset
// - hold reset until supply reaches power-on level
// - power-up timer gives 64 ms after power/brown-out
// - reset held while power-up timer runs
// - timer enabled when its config bit is zero
// - timer starts after power and brown-out release
// - brown-out holds reset while supply is low
// - two-bit field picks one of four modes
// - mode 11 always active, start waits ready
// - mode 10 off in sleep, wake waits ready
// - mode 01 follows soft enable, no wait
// - software mode protection ignores sleep
// - ready bit shows detector active state
// - soft enable bit 7 always rw, acts in 01
// - brown-out only after filter time elapses
// - one config bit selects brown-out level
// - pin reset off only if both bits zero
// - reset held while pin stays low
// - pin input filtered against short pulses
// - device never drives the reset pin
// - disabled pin is input, soft pull-up
// - run after timer, oscillator and pin release
//
// The placing of the registers and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "rss_params.svh"
module rss_top #(
  parameter int unsigned POWERUP_DELAY_TIMER_CYCLES = `RSS_POWERUP_DELAY_TIMER_CYCLES,
  parameter int unsigned BOR_FILT_CYCLES = `RSS_BOR_FILT_CYCLES,
  parameter int unsigned PIN_FILT_CYCLES = `RSS_PIN_FILT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [`RSS_ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire rss_pkg::rss_config_type config_i,
  input wire rss_pkg::rss_source_type source_i,
  input wire logic sleep_i,
  input wire logic oscillator_ready_i,
  input wire logic supply_above_por_i,
  input wire logic supply_below_threshold_i,
  input wire logic brownout_detector_ready_i,
  input wire logic external_reset_pin_i,
  output logic external_reset_pin_o,
  output logic external_reset_pin_oe_o,
  output logic pin_pullup_enable_o,
  output logic gpio_level_o,
  output logic brownout_detector_enable_o,
  output logic brownout_level_select_o,
  output logic wake_hold_o,
  output logic core_reset_o
);
  import rss_pkg::*;

  // ==========================================================
  // state and reset value
  // ==========================================================
  rss_state_type r;
  rss_state_type next_r;

  localparam rss_state_type RSS_RST = '{
    sync1: `RSS_RST_SYNC,
    sync2: `RSS_RST_SYNC,
    phase: RSS_PH_POWER,
    powerup_delay_timer_count: '0,
    bor_count: '0,
    bor_hold: 1'b0,
    pin_count: '0,
    pin_filt: 1'b1,
    soft_enable: `RSS_RST_SOFT_ENABLE,
    pullup_soft: `RSS_RST_PULLUP,
    core_reset: 1'b1,
    ack: 1'b0,
    rdata: 32'h0000_0000
  };

  localparam logic [`RSS_POWERUP_DELAY_TIMER_W-1:0] POWERUP_DELAY_TIMER_LAST =
    `RSS_POWERUP_DELAY_TIMER_W'(POWERUP_DELAY_TIMER_CYCLES - 1);
  localparam logic [`RSS_FILT_W-1:0] BOR_FILT_LAST =
    `RSS_FILT_W'(BOR_FILT_CYCLES);
  localparam logic [`RSS_FILT_W-1:0] PIN_FILT_LAST =
    `RSS_FILT_W'(PIN_FILT_CYCLES - 1);

  // ==========================================================
  // helpers
  // ==========================================================
  function automatic logic rss_hit(
    input logic [`RSS_ADR_W-1:0] adr,
    input logic [`RSS_ADR_W-1:0] target
  );
    rss_hit = (adr == target);
  endfunction : rss_hit

  // ==========================================================
  // combinational view of the synchronised inputs
  // ==========================================================
  logic por_ok;
  logic supply_below;
  logic det_ready;
  logic pin_level;
  logic det_enable;
  logic ready_status;
  logic protect;
  logic start_waits;
  logic start_ok;
  logic pin_enabled;
  logic pin_hold;
  logic power_fault;
  logic soft_reset;
  logic wb_req;
  logic wb_write;

  always_comb begin
    por_ok = r.sync2[`RSS_SYNC_POR];
    supply_below = r.sync2[`RSS_SYNC_BELOW];
    det_ready = r.sync2[`RSS_SYNC_READY];
    pin_level = r.sync2[`RSS_SYNC_PIN];
    // detector enable per mode
    unique case (config_i.brownout_mode_select)
      `RSS_MODE_ALWAYS_ACTIVE: begin
        det_enable = 1'b1;
      end
      `RSS_MODE_OFF_IN_SLEEP: begin
        det_enable = ~sleep_i;
      end
      `RSS_MODE_SOFTWARE: begin
        det_enable = r.soft_enable;
      end
      `RSS_MODE_ALWAYS_INACTIVE: begin
        det_enable = 1'b0;
      end
    endcase
    ready_status = det_enable & det_ready;
    protect = ready_status;
    start_waits =
      (config_i.brownout_mode_select == `RSS_MODE_ALWAYS_ACTIVE) |
      (config_i.brownout_mode_select == `RSS_MODE_OFF_IN_SLEEP);
    start_ok = por_ok & ~r.bor_hold &
      (~start_waits | (ready_status & ~supply_below));
    pin_enabled = config_i.external_reset_pin_enable |
      config_i.low_voltage_program_enable;
    pin_hold = pin_enabled & ~r.pin_filt;
    power_fault = ~por_ok | r.bor_hold |
      source_i.program_mode_exit;
    soft_reset = source_i.watchdog_timeout |
      source_i.reset_instruction |
      source_i.stack_overflow |
      source_i.stack_underflow;
    wb_req = wb_cyc_i & wb_stb_i & ~r.ack;
    wb_write = wb_req & wb_we_i & wb_sel_i[0];
  end

  // ==========================================================
  // next state
  // ==========================================================
  always_comb begin
    next_r = r;
    // two-stage synchronisers for the analog and pin inputs
    next_r.sync1[`RSS_SYNC_POR] = supply_above_por_i;
    next_r.sync1[`RSS_SYNC_BELOW] = supply_below_threshold_i;
    next_r.sync1[`RSS_SYNC_READY] = brownout_detector_ready_i;
    next_r.sync1[`RSS_SYNC_PIN] = external_reset_pin_i;
    next_r.sync2 = r.sync1;

    // ========================================================
    // brown-out noise filter
    // ========================================================
    if (protect & supply_below) begin
      if (r.bor_count == BOR_FILT_LAST) begin
        next_r.bor_hold = 1'b1;
      end else begin
        next_r.bor_count = r.bor_count + 1'b1;
      end
    end else begin
      next_r.bor_count = '0;
      next_r.bor_hold = 1'b0;
    end

    // ========================================================
    // reset pin noise filter
    // ========================================================
    if (pin_level != r.pin_filt) begin
      if (r.pin_count == PIN_FILT_LAST) begin
        next_r.pin_filt = pin_level;
        next_r.pin_count = '0;
      end else begin
        next_r.pin_count = r.pin_count + 1'b1;
      end
    end else begin
      next_r.pin_count = '0;
    end

    // ========================================================
    // start-up phases
    // ========================================================
    unique case (r.phase)
      RSS_PH_POWER: begin
        next_r.powerup_delay_timer_count = '0;
        if (start_ok) begin
          if (~config_i.powerup_delay_enable_n) begin
            next_r.phase = RSS_PH_TIMER;
          end else begin
            next_r.phase = RSS_PH_OSC;
          end
        end
      end
      RSS_PH_TIMER: begin
        if (r.powerup_delay_timer_count == POWERUP_DELAY_TIMER_LAST) begin
          next_r.phase = RSS_PH_OSC;
        end else begin
          next_r.powerup_delay_timer_count = r.powerup_delay_timer_count + 1'b1;
        end
      end
      RSS_PH_OSC: begin
        if (oscillator_ready_i) begin
          next_r.phase = RSS_PH_RUN;
        end
      end
      RSS_PH_RUN: begin
        next_r.phase = RSS_PH_RUN;
      end
    endcase
    if (power_fault) begin
      next_r.phase = RSS_PH_POWER;
      next_r.powerup_delay_timer_count = '0;
    end

    // combined core reset, released on a clock edge
    next_r.core_reset = (next_r.phase != RSS_PH_RUN) |
      pin_hold | soft_reset;

    // ========================================================
    // wishbone register slave
    // ========================================================
    next_r.ack = wb_req;
    next_r.rdata = 32'h0000_0000;
    if (wb_write & rss_hit(wb_adr_i, `RSS_ADR_BROWNOUT_CONTROL)) begin
      next_r.soft_enable = wb_dat_i[`RSS_BIT_SOFT_ENABLE];
    end
    if (wb_write & rss_hit(wb_adr_i, `RSS_ADR_PIN_CONTROL)) begin
      next_r.pullup_soft = wb_dat_i[`RSS_BIT_PULLUP];
    end
    if (wb_req & ~wb_we_i) begin
      if (rss_hit(wb_adr_i, `RSS_ADR_BROWNOUT_CONTROL)) begin
        next_r.rdata[`RSS_BIT_SOFT_ENABLE] = r.soft_enable;
        next_r.rdata[`RSS_BIT_READY] = ready_status;
      end
      if (rss_hit(wb_adr_i, `RSS_ADR_PIN_CONTROL)) begin
        next_r.rdata[`RSS_BIT_PULLUP] = r.pullup_soft;
        next_r.rdata[`RSS_BIT_PIN_LEVEL] = pin_level;
      end
      if (rss_hit(wb_adr_i, `RSS_ADR_RESET_STATUS)) begin
        next_r.rdata[`RSS_BIT_CORE_RESET] = r.core_reset;
        next_r.rdata[`RSS_BIT_BOR_HOLD] = r.bor_hold;
        next_r.rdata[`RSS_BIT_PIN_HOLD] = pin_hold;
        next_r.rdata[`RSS_BIT_PHASE_HI:`RSS_BIT_PHASE_LO] = r.phase;
      end
    end
  end

  // ==========================================================
  // state register
  // ==========================================================
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= RSS_RST;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // outputs
  // ==========================================================
  assign wb_dat_o = r.rdata;
  assign wb_ack_o = r.ack;
  assign core_reset_o = r.core_reset;
  assign external_reset_pin_o = 1'b0;
  assign external_reset_pin_oe_o = 1'b0;
  assign pin_pullup_enable_o = pin_enabled | r.pullup_soft;
  assign gpio_level_o = r.sync2[`RSS_SYNC_PIN];
  assign brownout_detector_enable_o = det_enable;
  assign brownout_level_select_o =
    config_i.brownout_level_select;
  assign wake_hold_o = (config_i.brownout_mode_select ==
    `RSS_MODE_OFF_IN_SLEEP) & ~ready_status;
endmodule : rss_top

// *** rss_properties.sv ***
// checker on the reset source sequencer ports
`timescale 1ns/1ps
`include "rss_params.svh"
module rss_properties #(
  parameter int unsigned PIN_FILT_CYCLES = `RSS_PIN_FILT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire rss_pkg::rss_config_type config_i,
  input wire rss_pkg::rss_source_type source_i,
  input wire logic sleep_i,
  input wire logic oscillator_ready_i,
  input wire logic supply_above_por_i,
  input wire logic external_reset_pin_i,
  input wire logic external_reset_pin_oe_o,
  input wire logic brownout_detector_enable_o,
  input wire logic brownout_level_select_o,
  input wire logic wake_hold_o,
  input wire logic core_reset_o
);
  import rss_pkg::*;
  // pin low to core reset: two sync flops, the filter, then the register
  localparam int unsigned PIN_HOLD_LAT = PIN_FILT_CYCLES + 3;
  logic [1:0] md;
  logic pin_en;
  logic [7:0] pin_low_run;
  assign md = config_i.brownout_mode_select;
  assign pin_en = config_i.external_reset_pin_enable |
    config_i.low_voltage_program_enable;
  // counts cycles of an enabled pin held low
  always_ff @(posedge clk_i) begin
    if (rst_i || !(pin_en && !external_reset_pin_i)) begin
      pin_low_run <= 8'h00;
    end else if (pin_low_run != 8'hFF) begin
      pin_low_run <= pin_low_run + 8'h01;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ====
  // sequences
  sequence por_low;
    !supply_above_por_i[*6];
  endsequence
  a_pin_undriven: assert property (!external_reset_pin_oe_o)
    else $error("pin driven");
  a_level_copy: assert property (
    brownout_level_select_o == config_i.brownout_level_select)
    else $error("level copy");
  a_soft_sources: assert property (
    |source_i[4:1] |=> core_reset_o)
    else $error("soft source");
  a_por_hold: assert property (por_low |-> core_reset_o)
    else $error("low supply");
  a_pin_hold: assert property (
    pin_low_run == PIN_HOLD_LAT |-> core_reset_o)
    else $error("pin low");
  a_run_ready: assert property (
    $fell(core_reset_o) |-> $past(oscillator_ready_i))
    else $error("oscillator");
  a_mode_off: assert property (
    md == 2'h0 |-> !brownout_detector_enable_o)
    else $error("mode 00");
  a_mode_on: assert property (
    md == 2'h3 |-> brownout_detector_enable_o)
    else $error("mode 11");
  a_sleep_off: assert property (
    md == 2'h2 && sleep_i |-> !brownout_detector_enable_o)
    else $error("sleep");
  a_wake_free: assert property (
    md != 2'h2 |-> !wake_hold_o)
    else $error("wake hold");
endmodule : rss_properties

bind rss_top rss_properties #(
  .PIN_FILT_CYCLES(PIN_FILT_CYCLES)
) i_rss_properties (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .config_i(config_i),
  .source_i(source_i),
  .sleep_i(sleep_i),
  .oscillator_ready_i(oscillator_ready_i),
  .supply_above_por_i(supply_above_por_i),
  .external_reset_pin_i(external_reset_pin_i),
  .external_reset_pin_oe_o(external_reset_pin_oe_o),
  .brownout_detector_enable_o(brownout_detector_enable_o),
  .brownout_level_select_o(brownout_level_select_o),
  .wake_hold_o(wake_hold_o),
  .core_reset_o(core_reset_o)
);

// *** rss_far_side.sv ***
// far-side model: supply monitors and external reset pin
`timescale 1ns/1ps
module rss_far_side (
  input wire logic por_ok_i,
  input wire logic dip_i,
  input wire logic pin_low_i,
  input wire logic pin_oe_i,
  input wire logic pin_drv_i,
  output logic por_o,
  output logic below_o,
  output logic pin_o
);
  assign por_o = por_ok_i;
  assign below_o = dip_i;
  // pull-up keeps the pin high unless held low
  assign pin_o = pin_oe_i ? pin_drv_i : !pin_low_i;
endmodule : rss_far_side

// *** reset_source_sequencer_test.sv ***
// self-checking bench of the reset source sequencer
`timescale 1ns/1ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin \
  error_cnt++; $display("Error t=%0t got %h exp %h", $time, a, e); end end
module reset_source_sequencer_test;
  import rss_pkg::*;
  localparam int PW = 20;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [3:0] wb_adr_i = '0, wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o;
  logic wb_ack_o, sleep_i = 0, oscillator_ready_i = 1, gpio_lo;
  logic supply_above_por_i, supply_below_threshold_i;
  logic brownout_detector_ready_i = 1, external_reset_pin_i;
  logic external_reset_pin_o, external_reset_pin_oe_o, pin_pullup_enable_o;
  logic gpio_level_o, brownout_detector_enable_o, brownout_level_select_o;
  logic wake_hold_o, core_reset_o, por_ok = 0, dip = 0, pin_low = 0;
  rss_config_type config_i = 6'h18;
  rss_source_type source_i = '0;
  int error_cnt = 0, check_count = 0, cycles = 0;
  rss_top #(.POWERUP_DELAY_TIMER_CYCLES(PW), .BOR_FILT_CYCLES(4), .PIN_FILT_CYCLES(3))
    i_rss_top (.*);
  rss_far_side i_rss_far_side (.por_ok_i(por_ok), .dip_i(dip),
    .pin_low_i(pin_low), .pin_oe_i(external_reset_pin_oe_o),
    .pin_drv_i(external_reset_pin_o), .por_o(supply_above_por_i),
    .below_o(supply_below_threshold_i), .pin_o(external_reset_pin_i));
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  // ====
  // tasks
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  task automatic bus(input logic w, input logic [3:0] a,
    input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, w};
    {wb_adr_i, wb_sel_i, wb_dat_i} <= {a, s, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
    @(posedge clk_i);
  endtask : bus
  task automatic cfg(input logic [5:0] c);
    @(posedge clk_i);
    config_i <= c;
  endtask : cfg
  task automatic wait_run(output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (core_reset_o !== 1'b0 && n < 300);
  endtask : wait_run
  task automatic boot(input logic [5:0] c, input int lag, output int n);
    {rst_i, por_ok} <= 2'h2;
    config_i <= c;
    repeat (6) @(posedge clk_i);
    rst_i <= 0;
    repeat (lag) @(posedge clk_i);
    por_ok <= 1;
    wait_run(n);
    n = n + lag;
  endtask : boot
  task automatic t_regs();
    logic [31:0] q;
    bus(1, 4'h0, 32'h0, 4'hE, q);
    bus(0, 4'h0, 32'h0, 4'hF, q);
    `CHK(q, 32'h81)
    bus(1, 4'h0, 32'h0, 4'h1, q);
    bus(0, 4'h0, 32'h0, 4'hF, q);
    `CHK(q, 32'h01)
    bus(0, 4'hC, 32'h0, 4'hF, q);
    `CHK(q, 32'h0)
    bus(1, 4'h0, 32'h80, 4'hF, q);
    cfg(6'h20);
    bus(0, 4'h0, 32'h0, 4'hF, q);
    `CHK(q, 32'h80)
    cfg(6'h38);
  endtask : t_regs
  task automatic t_soft();
    int k;
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_i);
      source_i <= rss_source_type'(5'h1 << i);
      @(posedge clk_i);
      source_i <= '0;
      #1 `CHK(core_reset_o, 1'b1)
      wait_run(k);
      `CHK(core_reset_o, 1'b0)
    end
  endtask : t_soft
  task automatic t_osc();
    int n;
    @(posedge clk_i);
    oscillator_ready_i <= 0;
    source_i <= rss_source_type'(5'h01);
    @(posedge clk_i);
    source_i <= '0;
    repeat (20) @(posedge clk_i);
    `CHK(core_reset_o, 1'b1)
    oscillator_ready_i <= 1;
    wait_run(n);
    `CHK(n < 5, 1'b1)
  endtask : t_osc
  task automatic t_dip(input bit pin, input int len, input logic exp);
    logic hit;
    int n;
    hit = 0;
    gpio_lo = 0;
    for (int k = 0; k < len + 12; k++) begin
      @(posedge clk_i);
      if (pin) pin_low <= (k < len);
      else dip <= (k < len);
      #1 hit = hit | core_reset_o;
      gpio_lo = gpio_lo | !gpio_level_o;
    end
    `CHK(hit, exp)
    wait_run(n);
  endtask : t_dip
  task automatic t_sbor();
    logic [31:0] q;
    cfg(6'h28);
    bus(1, 4'h0, 32'h0, 4'h1, q);
    t_dip(0, 12, 0);
    `CHK(brownout_detector_enable_o, 1'b0)
    bus(1, 4'h0, 32'h80, 4'h1, q);
    t_dip(0, 12, 1);
  endtask : t_sbor
  initial begin
    int n;
    logic [31:0] q;
    boot(6'h18, 30, n);
    `CHK(n > 30 + PW, 1'b1)
    boot(6'h38, 0, n);
    `CHK(n < PW, 1'b1)
    t_regs();
    bus(0, 4'h8, 32'h0, 4'hF, q);
    `CHK(q, 32'h30)
    t_soft();
    t_osc();
    t_dip(0, 2, 0);
    t_dip(0, 12, 1);
    sleep_i <= 1;
    t_dip(0, 12, 1);
    cfg(6'h30);
    t_dip(0, 12, 0);
    `CHK(wake_hold_o, 1'b1)
    t_sbor();
    sleep_i <= 0;
    cfg(6'h20);
    t_dip(0, 12, 0);
    cfg(6'h3E);
    t_dip(1, 2, 0);
    `CHK(brownout_level_select_o, 1'b1)
    t_dip(1, 12, 1);
    `CHK(external_reset_pin_oe_o, 1'b0)
    cfg(6'h39);
    t_dip(1, 12, 1);
    cfg(6'h38);
    t_dip(1, 12, 0);
    `CHK(gpio_lo, 1'b1)
    `CHK(pin_pullup_enable_o, 1'b0)
    bus(1, 4'h4, 32'h1, 4'h1, q);
    `CHK(pin_pullup_enable_o, 1'b1)
    bus(0, 4'h4, 32'h0, 4'hF, q);
    `CHK(q, 32'h3)
    close_out();
  end
endmodule : reset_source_sequencer_test
